// >>> reset_source_sequencer.sv
`timescale 1ns/1ps
// Contract
// R1 - every source asserts internal reset, vector fetch
// R2 - internal reset clears counter, pin keeps
// R3 - low reset pin halts processing at once
// R4 - pin flag needs 67 low cycles
// R5 - with power-on or brownout needs 4163
// R6 - internal sources drive pin 32 cycles
// R7 - internal reset holds 32 more cycles
// R8 - power-on/brownout drive pin 4096+32 cycles
// R9 - power-on gates cpu clocks 4096 cycles; code keeps coreClkEn on, gates only busClkEn through drive and tail
// R10 - cpu released 32 cycles after pin drive
// R11 - power-on sets its flag, clears others
// R12 - watchdog overflow resets, sets watchdog flag
// R13 - watchdog disabled by test voltage conditions
// R14 - bad opcode sets flag and resets
// R15 - stop with stop disabled is bad opcode
// R16 - only opcode fetch unmapped resets
// R17 - brownout sets flag, long pin drive
// R18 - monitor entry request resets, drives pin
// R19 - counter 13 bits on reference clock
// R20 - stop instruction clears counter
// R21 - wake waits 32 or 4096 cycles
// R22 - counter runs free after reset
// R23 - cause register read-only, fixed bit layout
// R24 - async requests synchronised before use
module reset_source_sequencer (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic power_on_pulse,
   input wire logic resetPinIn,
   output logic resetPinOut,
   output logic resetPinOe,
   input wire logic watchdogTimeout,
   input wire logic brownoutDetect,
   input wire logic monitorEntryReset,
   input wire logic badOpcode,
   input wire logic stopInstr,
   input wire logic opcodeFetch,
   input wire logic unmappedAccess,
   input wire logic monitorMode,
   input wire logic breakState,
   input wire logic testHvResetPin,
   input wire logic testHvIrqPin,
   input wire logic wakeEvent,
   output logic internalResetLine,
   output logic cpuHalt,
   output logic coreClkEn,
   output logic busClkEn,
   output logic watchdogEnable,
   output logic [15:0] resetVector,
   output logic [rss_pkg::CNT_W-1:0] stabCount,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   import rss_pkg::*;

   rss_state_e state;
   logic wdtSync;
   logic pinLowSync;
   logic [7:0] cause;
   logic [1:0] ctrl;
   logic longDrive;
   logic [12:0] pinLowCnt;
   logic pinFlagged;
   logic porSeen;
   logic next_wdt;
   logic badStop;
   logic badFetch;
   logic intReq;
   logic longReq;
   logic [CNT_W-1:0] wakeLast;
   logic driveDone;
   logic tailDone;

   rss_sync u_sync_wdt (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .din(watchdogTimeout),
      .dout(wdtSync)
   ); // R24
   rss_sync u_sync_pin (
      .ref_clk(ref_clk),
      .nrst(nrst),
      .din(~resetPinIn),
      .dout(pinLowSync)
   ); // R24

   assign next_wdt = wdtSync & watchdogEnable; // R12
   assign badStop = stopInstr & ~ctrl[B_STOPEN]; // R15
   assign badFetch = opcodeFetch & unmappedAccess; // R16
   assign longReq = power_on_pulse | brownoutDetect;
   assign intReq = longReq | next_wdt | badOpcode | badStop | badFetch
      | monitorEntryReset; // R14 R18
   assign wakeLast = ctrl[B_SHORTW] ? WAKE_SHORT_LAST : WAKE_LONG_LAST; // R21
   // last cycle of a phase, so registered pins drop right on the count
   assign driveDone = state == RSS_DRIVE
      && stabCount == (longDrive ? POR_DRIVE_LAST : PIN_DRIVE_LAST); // R6 R8
   assign tailDone = state == RSS_TAIL && !pinLowSync
      && stabCount[4:0] == TAIL_LAST[4:0]; // R7

   // sequencer
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         state <= RSS_DRIVE;
         longDrive <= 1'b1;
         stabCount <= CNT_RST;
      end else if (intReq) begin
         state <= RSS_DRIVE; // R1
         longDrive <= longReq; // R8 R17
         stabCount <= CNT_RST; // R2
      end else begin
         unique case (state)
            RSS_RUN: begin
               stabCount <= stabCount + 13'h0001; // R19 R22
               if (stopInstr) begin
                  state <= RSS_STOP;
                  stabCount <= CNT_RST; // R20
               end else if (pinLowSync) begin
                  state <= RSS_TAIL; // R2
               end
            end
            RSS_DRIVE: begin
               stabCount <= stabCount + 13'h0001;
               if (stabCount == (longDrive ? POR_DRIVE_LAST
                     : PIN_DRIVE_LAST)) begin // R6 R8
                  state <= RSS_TAIL;
                  stabCount <= CNT_RST;
               end
            end
            RSS_TAIL: begin
               stabCount <= stabCount + 13'h0001;
               if (pinLowSync) begin
                  state <= RSS_TAIL; // R3
               end else if (stabCount[4:0] == TAIL_LAST[4:0]) begin
                  state <= RSS_RUN; // R7 R10
               end
            end
            RSS_STOP: begin
               if (wakeEvent || pinLowSync) begin
                  state <= RSS_WAKE;
               end
            end
            RSS_WAKE: begin
               stabCount <= stabCount + 13'h0001;
               if (stabCount == wakeLast) begin
                  state <= RSS_RUN; // R21
               end
            end
            default: begin
               state <= RSS_DRIVE;
            end
         endcase
      end
   end

   // outputs, registered
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         resetPinOut <= 1'b0;
         resetPinOe <= 1'b1;
         internalResetLine <= 1'b1;
         cpuHalt <= 1'b1;
         coreClkEn <= 1'b1;
         busClkEn <= 1'b0;
         resetVector <= VEC_NORMAL;
      end else begin
         resetPinOut <= 1'b0;
         resetPinOe <= intReq || (state == RSS_DRIVE && !driveDone); // R6 R8
         internalResetLine <= intReq || pinLowSync
            || (state == RSS_DRIVE)
            || (state == RSS_TAIL && !tailDone); // R1 R3
         cpuHalt <= intReq || pinLowSync
            || (state != RSS_RUN && !tailDone); // R3
         coreClkEn <= 1'b1; // R9
         busClkEn <= !intReq && (state == RSS_RUN || state == RSS_TAIL
            && !longDrive); // R9
         resetVector <= monitorMode ? VEC_MONITOR : VEC_NORMAL; // R1
      end
   end

   // gate registered like every output, so it lags its test inputs one cycle
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         watchdogEnable <= 1'b1;
      end else begin
         watchdogEnable <= !((monitorMode && (testHvResetPin || testHvIrqPin))
            || (breakState && testHvResetPin)); // R13
      end
   end

   // pin low duration measure
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         pinLowCnt <= 13'h0000;
         pinFlagged <= 1'b0;
      end else if (!pinLowSync) begin
         pinLowCnt <= 13'h0000;
         pinFlagged <= 1'b0;
      end else begin
         if (pinLowCnt != 13'h1FFF) begin
            pinLowCnt <= pinLowCnt + 13'h0001;
         end
         if (pinLowCnt == (porSeen ? PIN_MIN_POR_LAST : PIN_MIN_LAST)
               && !resetPinOe) begin // R4 R5
            pinFlagged <= 1'b1;
         end
      end
   end

   // power-on/brownout involvement, ends when sequence is done
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         porSeen <= 1'b1;
      end else if (longReq) begin
         porSeen <= 1'b1;
      end else if (state == RSS_RUN) begin
         porSeen <= 1'b0;
      end
   end

   // cause register, set wins, power-on clears others
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         cause <= CAUSE_POR_VAL;
      end else if (power_on_pulse) begin
         cause <= CAUSE_POR_VAL; // R11
      end else if (intReq || pinFlagged) begin
         cause[B_WDT] <= next_wdt; // R12
         cause[B_OPC] <= badOpcode | badStop; // R14 R15
         cause[B_ADR] <= badFetch; // R16
         cause[B_MON] <= monitorEntryReset; // R18
         cause[B_BOD] <= brownoutDetect; // R17
         cause[B_PIN] <= pinFlagged && !intReq; // R4
         cause[B_POR] <= 1'b0;
         cause[0] <= 1'b0; // R23
      end
   end

   // apb slave, zero wait
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         ctrl <= CTRL_RST;
      end else if (psel && penable && pwrite && paddr == CTRL_ADDR) begin
         ctrl <= pwdata[1:0];
      end
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && paddr != CTRL_ADDR
            && (paddr != CAUSE_ADDR || pwrite); // R23
         prdata <= 32'h0000_0000;
         if (psel && !penable && !pwrite) begin
            if (paddr == CAUSE_ADDR) begin
               prdata <= {24'h00_0000, cause}; // R23
            end else if (paddr == CTRL_ADDR) begin
               prdata <= {30'h0000_0000, ctrl};
            end
         end
      end
   end

   property p_drive_short;
      @(posedge ref_clk) disable iff (!nrst)
      $rose(state == RSS_TAIL) && $past(state) == RSS_DRIVE && !longDrive
         |-> $past(stabCount) == PIN_DRIVE_LAST;
   endproperty
   a_drive_short: assert property (p_drive_short) // R6
      else $error("short drive length wrong");
   property p_tail;
      @(posedge ref_clk) disable iff (!nrst)
      $fell(state == RSS_TAIL) && state == RSS_RUN
         |-> $past(stabCount[4:0]) == TAIL_LAST[4:0];
   endproperty
   a_tail: assert property (p_tail) else $error("tail length wrong"); // R7
   property p_long;
      @(posedge ref_clk) disable iff (!nrst)
      state == RSS_TAIL && $past(state) == RSS_DRIVE && longDrive
         |-> $past(stabCount) == POR_DRIVE_LAST;
   endproperty
   a_long: assert property (p_long) else $error("long drive wrong"); // R8
   property p_oe;
      @(posedge ref_clk) disable iff (!nrst)
      state == RSS_DRIVE && !intReq |=> resetPinOe == !$past(driveDone);
   endproperty
   a_oe: assert property (p_oe) else $error("pin not driven"); // R6
   property p_halt;
      @(posedge ref_clk) disable iff (!nrst)
      pinLowSync |=> cpuHalt && internalResetLine;
   endproperty
   a_halt: assert property (p_halt) else $error("pin low not halting"); // R3
   property p_por;
      @(posedge ref_clk) disable iff (!nrst)
      power_on_pulse |=> cause == CAUSE_POR_VAL;
   endproperty
   a_por: assert property (p_por) else $error("power-on flag wrong"); // R11
   property p_stop;
      @(posedge ref_clk) disable iff (!nrst)
      state == RSS_RUN && stopInstr && !intReq |=> stabCount == CNT_RST;
   endproperty
   a_stop: assert property (p_stop) else $error("stop not clearing"); // R20
   property p_wdt;
      @(posedge ref_clk) disable iff (!nrst)
      next_wdt && !power_on_pulse |=> cause[B_WDT] && state == RSS_DRIVE;
   endproperty
   a_wdt: assert property (p_wdt) else $error("watchdog not taken"); // R12
   property p_fetch;
      @(posedge ref_clk) disable iff (!nrst)
      unmappedAccess && !opcodeFetch && state == RSS_RUN && !intReq
         && !pinLowSync && !stopInstr |=> state == RSS_RUN;
   endproperty
   a_fetch: assert property (p_fetch) else $error("data access reset"); // R16
   property p_bus_por;
      @(posedge ref_clk) disable iff (!nrst)
      state == RSS_DRIVE && longDrive |=> !busClkEn;
   endproperty
   a_bus_por: assert property (p_bus_por) else $error("bus clock on"); // R9
   property p_vec;
      @(posedge ref_clk) disable iff (!nrst)
      monitorMode |=> resetVector == VEC_MONITOR;
   endproperty
   a_vec: assert property (p_vec) else $error("monitor vector wrong"); // R1
   // bus clocks stay off for the whole oscillator wait
   property p_wake;
      @(posedge ref_clk) disable iff (!nrst)
      state == RSS_WAKE |=> !busClkEn;
   endproperty
   a_wake: assert property (p_wake) else $error("bus clock in wake"); // R21
   c_wdt: cover property (@(posedge ref_clk) disable iff (!nrst) next_wdt);
   c_wake: cover property (@(posedge ref_clk) disable iff (!nrst)
      state == RSS_WAKE ##1 state == RSS_RUN);
   c_pin: cover property (@(posedge ref_clk) disable iff (!nrst)
      $rose(cause[B_PIN]));
   c_por: cover property (@(posedge ref_clk) disable iff (!nrst)
      power_on_pulse);
endmodule

// >>> rss_pkg.sv
package rss_pkg;
   localparam int unsigned CLK_MHZ = 250;
   localparam int unsigned CNT_W = 13;
   localparam logic [CNT_W-1:0] CNT_RST = 13'h0000;
   // oscillator reference cycle counts
   localparam int unsigned PIN_DRIVE_CYC = 32;
   localparam int unsigned TAIL_CYC = 32;
   localparam int unsigned STAB_CYC = 4096;
   localparam int unsigned PIN_MIN_CYC = 67;
   localparam int unsigned PIN_MIN_POR_CYC = 4163;
   localparam int unsigned WAKE_SHORT_CYC = 32;
   localparam logic [CNT_W-1:0] PIN_DRIVE_LAST = 13'h001F;
   localparam logic [CNT_W-1:0] TAIL_LAST = 13'h001F;
   localparam logic [CNT_W-1:0] POR_DRIVE_LAST = 13'h101F;
   localparam logic [CNT_W-1:0] WAKE_LONG_LAST = 13'h0FFF;
   localparam logic [CNT_W-1:0] WAKE_SHORT_LAST = 13'h001F;
   localparam logic [12:0] PIN_MIN_LAST = 13'h0042;
   localparam logic [12:0] PIN_MIN_POR_LAST = 13'h1042;
   // apb map
   // register index; the bus address is four times it
   localparam logic [15:0] CAUSE_OFS = 16'hFE01;
   localparam logic [31:0] CAUSE_ADDR = 32'h0003_F804;
   localparam logic [31:0] CTRL_ADDR = 32'h0003_F808;
   localparam logic [15:0] VEC_NORMAL = 16'hFFFE;
   localparam logic [15:0] VEC_MONITOR = 16'hFEFE;
   localparam int unsigned B_POR = 7;
   localparam int unsigned B_PIN = 6;
   localparam int unsigned B_WDT = 5;
   localparam int unsigned B_OPC = 4;
   localparam int unsigned B_ADR = 3;
   localparam int unsigned B_MON = 2;
   localparam int unsigned B_BOD = 1;
   localparam int unsigned B_STOPEN = 0;
   localparam int unsigned B_SHORTW = 1;
   localparam logic [7:0] CAUSE_POR_VAL = 8'h80;
   localparam logic [1:0] CTRL_RST = 2'h0;
   typedef enum logic [2:0] {
      RSS_RUN = 3'b000,
      RSS_DRIVE = 3'b001,
      RSS_TAIL = 3'b011,
      RSS_STOP = 3'b010,
      RSS_WAKE = 3'b110
   } rss_state_e;
endpackage

// >>> rss_sync.sv
`timescale 1ns/1ps
module rss_sync (
   input wire logic ref_clk,
   input wire logic nrst,
   input wire logic din,
   output logic dout
);
   logic stage1;
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         stage1 <= 1'b0;
         dout <= 1'b0;
      end else begin
         stage1 <= din;
         dout <= stage1;
      end
   end
endmodule

// >>> rss_pin_model.sv
`timescale 1ns/1ps
// reset pin wire with its pull-up; outside party may pull it low
module rss_pin_model (
   input wire logic pullLow,
   input wire logic pinOut,
   input wire logic pinOe,
   output logic pinLevel
);
   // pull-up only when nobody drives the wire, never the last value
   assign pinLevel = pullLow ? 1'b0 : (pinOe ? pinOut : 1'b1);
endmodule

// >>> reset_source_sequencer_test.sv
`timescale 1ns/1ps
module reset_source_sequencer_test;
   import rss_pkg::*;
   logic ref_clk = 0, nrst = 0, pwr = 1, pull = 0, err;
   logic pinLevel, pinOut, pinOe, internal_reset_line, halt, coreEn, busEn, wdEn;
   // badOp wdt mon bod fetch unmapped stop
   logic [6:0] req = '0;
   logic [3:0] tm = '0;
   logic wake = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
   logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
   logic [15:0] vec;
   logic [CNT_W-1:0] cnt;
   int failures = 0, checks_done = 0, n;
   rss_pin_model pin (.pullLow(pull), .pinOut(pinOut), .pinOe(pinOe),
      .pinLevel(pinLevel));
   reset_source_sequencer dut (.ref_clk(ref_clk), .nrst(nrst),
      .power_on_pulse(pwr), .resetPinIn(pinLevel), .resetPinOut(pinOut),
      .resetPinOe(pinOe), .watchdogTimeout(req[1]),
      .brownoutDetect(req[3]), .monitorEntryReset(req[2]),
      .badOpcode(req[0]), .stopInstr(req[6]), .opcodeFetch(req[4]),
      .unmappedAccess(req[5]), .monitorMode(tm[3]), .breakState(tm[2]),
      .testHvResetPin(tm[1]), .testHvIrqPin(tm[0]), .wakeEvent(wake),
      .internalResetLine(internal_reset_line), .cpuHalt(halt), .coreClkEn(coreEn),
      .busClkEn(busEn), .watchdogEnable(wdEn), .resetVector(vec),
      .stabCount(cnt), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   initial begin
      forever #2 ref_clk = ~ref_clk;
   end
   task automatic give_verdict();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic check(string nm, logic [31:0] e, logic [31:0] g);
      checks_done++;
      if (e !== g) begin
         failures++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic apb(logic w, logic [31:0] a, logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic wait_cyc(int k);
      repeat (k) @(posedge ref_clk);
   endtask
   // times pin drive and tail, then reads the cause flag
   task automatic measure(int drv, logic [7:0] flag);
      while (pinOe !== 1'b1) @(posedge ref_clk);
      check("internal_reset_line", 1, internal_reset_line);
      check("cntClr", 1, cnt < 3);
      n = 0;
      while (pinOe === 1'b1) begin
         @(posedge ref_clk);
         n++;
      end
      check("drive", drv, n);
      n = 0;
      while (halt === 1'b1) begin
         @(posedge ref_clk);
         n++;
      end
      check("tail", 1, n >= TAIL_CYC - 1 && n <= TAIL_CYC + 1);
      check("irstOff", 0, internal_reset_line);
      apb(0, CAUSE_ADDR, 0);
      check("flag", flag, rd[7:0] & flag);
   endtask
   task automatic fire(logic [6:0] m, int drv, logic [7:0] flag);
      @(posedge ref_clk);
      req <= m;
      @(posedge ref_clk);
      req <= 0;
      measure(drv, flag);
   endtask
   initial begin
      #240000;
      failures++;
      give_verdict();
   end
   initial begin
      wait_cyc(6);
      nrst <= 1;
      pwr <= 0;
      wait_cyc(1);
      check("coreEn", 1, coreEn);
      check("busEn", 0, busEn);
      measure(STAB_CYC + PIN_DRIVE_CYC, CAUSE_POR_VAL);
      check("cause", CAUSE_POR_VAL, rd);
      check("vec", VEC_NORMAL, vec);
      fire(7'h01, PIN_DRIVE_CYC, 8'h10);
      fire(7'h02, PIN_DRIVE_CYC, 8'h20);
      fire(7'h04, PIN_DRIVE_CYC, 8'h04);
      fire(7'h30, PIN_DRIVE_CYC, 8'h08);
      fire(7'h40, PIN_DRIVE_CYC, 8'h10);
      fire(7'h08, STAB_CYC + PIN_DRIVE_CYC, 8'h02);
      check("bit0", 0, rd[0]);
      @(posedge ref_clk);
      req <= 7'h20;
      @(posedge ref_clk);
      req <= 0;
      wait_cyc(8);
      check("dataUnmapped", 0, pinOe | internal_reset_line);
      apb(1, CAUSE_ADDR, 0);
      check("roErr", 1, err);
      apb(0, 32'h0000_0000, 0);
      check("unmapErr", 1, err);
      // short wake then long wake, stop enabled in both
      for (int i = 0; i < 2; i++) begin
         apb(1, CTRL_ADDR, i ? 32'h0000_0001 : 32'h0000_0003);
         apb(0, CTRL_ADDR, 0);
         check("ctrl", i ? 1 : 3, rd[1:0]);
         @(posedge ref_clk);
         req <= 7'h40;
         @(posedge ref_clk);
         req <= 0;
         wait_cyc(3);
         check("stopBus", 0, busEn);
         check("stopCnt", 1, cnt < 4);
         wake <= 1;
         @(posedge ref_clk);
         wake <= 0;
         n = 0;
         while (busEn !== 1'b1) begin
            @(posedge ref_clk);
            n++;
         end
         check("wake", 1, n >= (i ? STAB_CYC : WAKE_SHORT_CYC) &&
            n <= (i ? STAB_CYC : WAKE_SHORT_CYC) + 3);
         n = int'(cnt);
         @(posedge ref_clk);
         check("freeRun", n + 1, cnt);
      end
      pull <= 1;
      wait_cyc(PIN_MIN_CYC + 20);
      check("pinHalt", 1, halt);
      pull <= 0;
      while (halt === 1'b1) @(posedge ref_clk);
      apb(0, CAUSE_ADDR, 0);
      check("pinFlag", 8'h40, rd[7:0] & 8'h40);
      foreach (tm[i]) begin
         @(posedge ref_clk);
         tm <= (i == 0) ? 4'b1001 : (i == 1) ? 4'b1010 : 4'b0110;
         wait_cyc(4);
         check("wdOff", 0, wdEn);
         check("vecMon", (i < 2) ? VEC_MONITOR : VEC_NORMAL, vec);
      end
      tm <= 0;
      wait_cyc(4);
      check("wdOn", 1, wdEn);
      // power-on in mid-run must wipe the pin flag left from above
      pwr <= 1;
      @(posedge ref_clk);
      pwr <= 0;
      measure(STAB_CYC + PIN_DRIVE_CYC, CAUSE_POR_VAL);
      check("porClr", CAUSE_POR_VAL, rd);
      give_verdict();
   end
endmodule
